/* hmpc_halt_ctrl.sv */
// halt mode power controller top
`timescale 1ns/1ps
`include "hmpc_map.svh"
`default_nettype none
module hmpc_halt_ctrl #(
  parameter int NPERIPH = 8,
  parameter int NWAKE = 6,
  parameter int unsigned WUP_CNT_SHORT = `HMPC_WUP_CNT_SHORT,
  parameter int unsigned WUP_CNT_MID = `HMPC_WUP_CNT_MID,
  parameter int unsigned WUP_CNT_LONG = `HMPC_WUP_CNT_LONG
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic HALT_REQ,
  input wire logic [`HMPC_MODE_W-1:0] HALT_MODE,
  input wire logic [NPERIPH-1:0] PERIPH_IDLE_ENABLE,
  input wire logic DRIVE_ENABLE,
  input wire logic RESUME_SLOW,
  input wire logic RESUME_HIGH_OSC_ENABLE,
  input wire logic RESUME_LOW_OSC_ENABLE,
  input wire logic [`HMPC_WUP_SEL_W-1:0] WARMUP_COUNT_SELECT,
  input wire logic HIGH_FREQ_CLOCK_TICK,
  input wire logic LOW_FREQ_CLOCK_TICK,
  input wire logic [NWAKE-1:0] WAKE_PIN,
  input wire logic [NWAKE-1:0] WAKE_ALLOW_PERIPH_IDLE,
  input wire logic [NWAKE-1:0] WAKE_ALLOW_OSC_IDLE,
  input wire logic [NWAKE-1:0] WAKE_ALLOW_STOP,
  output logic CPU_RUN_EN,
  output logic SYS_CLK_EN,
  output logic [NPERIPH-1:0] PERIPH_CLK_EN,
  output logic CLOCK_TIMER_EN,
  output logic HIGH_OSC_EN,
  output logic LOW_OSC_EN,
  output logic SLOW_MODE,
  output logic PIN_DRIVE_EN,
  output hmpc_pkg::hmpc_buf_t BUF_EN,
  output hmpc_pkg::hmpc_state_t HALT_STATE,
  output logic [NWAKE-1:0] WAKE_SOURCE,
  output logic WAKE_PULSE
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  hmpc_pkg::hmpc_state_t state_q;
  hmpc_pkg::hmpc_state_t state_d;
  hmpc_pkg::hmpc_cfg_t cfg_q;
  logic [NWAKE-1:0] wake_lvl;
  logic [NWAKE-1:0] wake_hit_now;
  logic wake_any;
  logic stop_entry;
  logic wup_done;
  logic halted_d;
  logic resume_now;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic [NWAKE-1:0] wake_hit(
    input hmpc_pkg::hmpc_state_t st,
    input logic [NWAKE-1:0] lvl,
    input logic [NWAKE-1:0] a_pidle,
    input logic [NWAKE-1:0] a_oidle,
    input logic [NWAKE-1:0] a_stop
  );
    logic [NWAKE-1:0] allow;
    allow = '0;
    case (st)
      hmpc_pkg::ST_PERIPH_IDLE: allow = a_pidle;
      hmpc_pkg::ST_OSC_IDLE: allow = a_oidle;
      hmpc_pkg::ST_STOP: allow = a_stop;
      default: allow = '0;
    endcase
    // non-maskable source always releases a halt
    if (st == hmpc_pkg::ST_PERIPH_IDLE || st == hmpc_pkg::ST_OSC_IDLE || st == hmpc_pkg::ST_STOP) begin
      allow[`HMPC_NMI_BIT] = 1'b1;
    end
    wake_hit = lvl & allow;
  endfunction : wake_hit

  function automatic logic is_halt(input hmpc_pkg::hmpc_state_t st);
    case (st)
      hmpc_pkg::ST_PERIPH_IDLE: is_halt = 1'b1;
      hmpc_pkg::ST_OSC_IDLE: is_halt = 1'b1;
      hmpc_pkg::ST_STOP: is_halt = 1'b1;
      hmpc_pkg::ST_WARMUP: is_halt = 1'b1;
      default: is_halt = 1'b0;
    endcase
  endfunction : is_halt

  ////////////////////////////////////////////////////////////////////////////
  // wake input capture, free of the gated system clock
  hmpc_sync3 #(
    .W(NWAKE)
  ) u_wake_sync (
    .clk(CLK),
    .nrst(NRST),
    .din(WAKE_PIN),
    .dout(wake_lvl)
  ); // RQ5

  assign wake_hit_now = wake_hit(state_q, wake_lvl, WAKE_ALLOW_PERIPH_IDLE, WAKE_ALLOW_OSC_IDLE,
                                 WAKE_ALLOW_STOP); // RQ14
  assign wake_any = |wake_hit_now;

  ////////////////////////////////////////////////////////////////////////////
  // halt sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      hmpc_pkg::ST_RUN: begin
        if (HALT_REQ) begin
          case (HALT_MODE)
            `HMPC_MODE_PERIPH_IDLE: state_d = hmpc_pkg::ST_PERIPH_IDLE;
            `HMPC_MODE_OSC_IDLE: state_d = hmpc_pkg::ST_OSC_IDLE;
            `HMPC_MODE_STOP: state_d = hmpc_pkg::ST_STOP;
            default: state_d = hmpc_pkg::ST_RUN;
          endcase
        end
      end
      hmpc_pkg::ST_PERIPH_IDLE: begin
        if (wake_any) begin
          state_d = hmpc_pkg::ST_RUN; // RQ14
        end
      end
      hmpc_pkg::ST_OSC_IDLE: begin
        if (wake_any) begin
          state_d = hmpc_pkg::ST_RUN; // RQ6
        end
      end
      hmpc_pkg::ST_STOP: begin
        if (wake_any) begin
          state_d = hmpc_pkg::ST_WARMUP; // RQ15
        end
      end
      hmpc_pkg::ST_WARMUP: begin
        if (wup_done) begin
          state_d = hmpc_pkg::ST_RUN; // RQ9
        end
      end
      default: state_d = hmpc_pkg::ST_RUN;
    endcase
  end

  // state moves on the clock edge, and to ST_RUN at once on reset
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= hmpc_pkg::ST_RUN; // RQ14
    end else begin
      state_q <= state_d; // RQ6
    end
  end

  assign stop_entry = (state_q == hmpc_pkg::ST_RUN) && (state_d == hmpc_pkg::ST_STOP);
  assign halted_d = is_halt(state_d);
  assign resume_now = is_halt(state_q) && !halted_d;

  ////////////////////////////////////////////////////////////////////////////
  // stop configuration taken at entry
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_q <= '0;
    end else if (stop_entry) begin
      cfg_q.resume_slow <= RESUME_SLOW; // RQ10
      cfg_q.warmup_count_select <= WARMUP_COUNT_SELECT; // RQ11
      cfg_q.drive_en <= DRIVE_ENABLE; // RQ8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // warm-up timing
  hmpc_warmup #(
    .CNT_SHORT(WUP_CNT_SHORT),
    .CNT_MID(WUP_CNT_MID),
    .CNT_LONG(WUP_CNT_LONG)
  ) u_warmup (
    .clk(CLK),
    .nrst(NRST),
    .clear(stop_entry),
    .run(state_q == hmpc_pkg::ST_WARMUP),
    .tick_high(HIGH_FREQ_CLOCK_TICK),
    .tick_low(LOW_FREQ_CLOCK_TICK),
    .cfg(cfg_q),
    .done(wup_done)
  ); // RQ16

  ////////////////////////////////////////////////////////////////////////////
  // cpu and clock gating
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      CPU_RUN_EN <= 1'b1;
    end else begin
      CPU_RUN_EN <= (state_d == hmpc_pkg::ST_RUN); // RQ2
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      SYS_CLK_EN <= 1'b1;
    end else begin
      SYS_CLK_EN <= (state_d == hmpc_pkg::ST_RUN) || (state_d == hmpc_pkg::ST_PERIPH_IDLE); // RQ4
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PERIPH_CLK_EN <= '1;
    end else begin
      case (state_d)
        hmpc_pkg::ST_RUN: PERIPH_CLK_EN <= '1;
        hmpc_pkg::ST_PERIPH_IDLE: PERIPH_CLK_EN <= PERIPH_IDLE_ENABLE; // RQ1
        default: PERIPH_CLK_EN <= '0; // RQ3
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      CLOCK_TIMER_EN <= 1'b1;
    end else begin
      CLOCK_TIMER_EN <= !(state_d == hmpc_pkg::ST_STOP || state_d == hmpc_pkg::ST_WARMUP); // RQ3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator control
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      HIGH_OSC_EN <= `HMPC_HIGH_OSC_RST;
      LOW_OSC_EN <= `HMPC_LOW_OSC_RST;
    end else if (state_d == hmpc_pkg::ST_STOP) begin
      HIGH_OSC_EN <= 1'b0; // RQ7
      LOW_OSC_EN <= 1'b0; // RQ7
    end else if (state_q == hmpc_pkg::ST_STOP) begin
      // resumed source forced on so its warm-up can count
      HIGH_OSC_EN <= RESUME_HIGH_OSC_ENABLE || !cfg_q.resume_slow; // RQ10
      LOW_OSC_EN <= RESUME_LOW_OSC_ENABLE || cfg_q.resume_slow; // RQ10
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      SLOW_MODE <= 1'b0;
    end else if (state_q == hmpc_pkg::ST_WARMUP && state_d == hmpc_pkg::ST_RUN) begin
      SLOW_MODE <= cfg_q.resume_slow; // RQ12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive and input buffer gating
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PIN_DRIVE_EN <= 1'b1;
    end else if (state_d == hmpc_pkg::ST_STOP || state_d == hmpc_pkg::ST_WARMUP) begin
      PIN_DRIVE_EN <= (state_q == hmpc_pkg::ST_RUN) ? DRIVE_ENABLE : cfg_q.drive_en; // RQ8
    end else begin
      PIN_DRIVE_EN <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      BUF_EN <= '0;
    end else begin
      case (state_d)
        hmpc_pkg::ST_RUN: BUF_EN <= '1;
        hmpc_pkg::ST_PERIPH_IDLE,
        hmpc_pkg::ST_OSC_IDLE: begin
          BUF_EN.muxed_bus_low_byte <= 1'b0; // RQ13
          BUF_EN.wait_req <= 1'b0; // RQ13
          BUF_EN.bus_request_input <= 1'b1;
          BUF_EN.wake <= 1'b1; // RQ13
          BUF_EN.port <= 1'b1;
        end
        hmpc_pkg::ST_STOP,
        hmpc_pkg::ST_WARMUP: begin
          BUF_EN.muxed_bus_low_byte <= 1'b0; // RQ13
          BUF_EN.wait_req <= 1'b0; // RQ13
          BUF_EN.bus_request_input <= (state_q == hmpc_pkg::ST_RUN) ? DRIVE_ENABLE : cfg_q.drive_en; // RQ13
          BUF_EN.wake <= (state_q == hmpc_pkg::ST_RUN) ? DRIVE_ENABLE : cfg_q.drive_en; // RQ13
          BUF_EN.port <= (state_q == hmpc_pkg::ST_RUN) ? DRIVE_ENABLE : cfg_q.drive_en; // RQ13
        end
        default: BUF_EN <= '1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status and wake reporting
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      HALT_STATE <= hmpc_pkg::ST_RUN;
    end else begin
      HALT_STATE <= state_d;
    end
  end

  // wake source held until the next release
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      WAKE_SOURCE <= '0;
    end else if (wake_any) begin
      WAKE_SOURCE <= wake_hit_now; // RQ14
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      WAKE_PULSE <= 1'b0;
    end else begin
      WAKE_PULSE <= resume_now; // RQ6
    end
  end

endmodule : hmpc_halt_ctrl
`default_nettype wire

/* hmpc_map.svh */
// constants for the halt mode power controller
// Operation
// RQ1 - peripheral idle runs only enabled peripherals
// RQ2 - peripheral idle stops all instruction execution
// RQ3 - oscillator idle keeps oscillator, clock timer
// RQ4 - oscillator idle gates off system clock
// RQ5 - wake requests sensed without system clock
// RQ6 - halt exit synchronous to system clock
// RQ7 - full stop halts everything, oscillator too
// RQ8 - stop pin state follows drive enable
// RQ9 - system clock waits for full warm-up
// RQ10 - resume select picks high or low clock
// RQ11 - warm-up codes select 2^8/2^14/2^16 ticks
// RQ12 - low clock stop may resume high
// RQ13 - input buffers gated per halt mode
// RQ14 - reset or accepted interrupt releases halt
// RQ15 - stop wake resumes only after warm-up
// RQ16 - warm-up clears on entry, counts after wake
`ifndef HMPC_MAP_SVH
`define HMPC_MAP_SVH

// halt mode request codes
`define HMPC_MODE_W 2
`define HMPC_MODE_NONE 2'h0
`define HMPC_MODE_STOP 2'h1
`define HMPC_MODE_OSC_IDLE 2'h2
`define HMPC_MODE_PERIPH_IDLE 2'h3

// warm-up select codes and tick counts
`define HMPC_WUP_SEL_W 2
`define HMPC_WUP_SEL_SHORT 2'h1
`define HMPC_WUP_SEL_MID 2'h2
`define HMPC_WUP_SEL_LONG 2'h3
`define HMPC_WUP_CNT_SHORT 256
`define HMPC_WUP_CNT_MID 16384
`define HMPC_WUP_CNT_LONG 65536
`define HMPC_WUP_CNT_W 17

// wake vector layout and reset values
`define HMPC_NMI_BIT 0
`define HMPC_HIGH_OSC_RST 1'h1
`define HMPC_LOW_OSC_RST 1'h0

`endif

/* hmpc_pkg.sv */
// types for the halt mode power controller
package hmpc_pkg;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_PERIPH_IDLE,
    ST_OSC_IDLE,
    ST_STOP,
    ST_WARMUP
  } hmpc_state_t;

  typedef struct packed {
    logic muxed_bus_low_byte;
    logic wait_req;
    logic bus_request_input;
    logic wake;
    logic port;
  } hmpc_buf_t;

  typedef struct packed {
    logic resume_slow;
    logic [1:0] warmup_count_select;
    logic drive_en;
  } hmpc_cfg_t;

endpackage : hmpc_pkg

/* hmpc_sync3.sv */
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module hmpc_sync3 #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // level accepted only when stages two and three agree
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          dout[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          dout[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule : hmpc_sync3
`default_nettype wire

/* hmpc_warmup.sv */
// oscillator warm-up counter
`timescale 1ns/1ps
`include "hmpc_map.svh"
`default_nettype none
module hmpc_warmup #(
  parameter int unsigned CNT_SHORT = `HMPC_WUP_CNT_SHORT,
  parameter int unsigned CNT_MID = `HMPC_WUP_CNT_MID,
  parameter int unsigned CNT_LONG = `HMPC_WUP_CNT_LONG
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clear,
  input wire logic run,
  input wire logic tick_high,
  input wire logic tick_low,
  input wire hmpc_pkg::hmpc_cfg_t cfg,
  output logic done
);
  logic [`HMPC_WUP_CNT_W-1:0] cnt_q;
  logic [`HMPC_WUP_CNT_W-1:0] target;
  logic tick;

  function automatic logic [`HMPC_WUP_CNT_W-1:0] wup_target(input logic [1:0] sel);
    case (sel)
      `HMPC_WUP_SEL_MID: wup_target = `HMPC_WUP_CNT_W'(CNT_MID);
      `HMPC_WUP_SEL_LONG: wup_target = `HMPC_WUP_CNT_W'(CNT_LONG);
      default: wup_target = `HMPC_WUP_CNT_W'(CNT_SHORT);
    endcase
  endfunction : wup_target

  // count ticks of the resumed source only
  assign tick = cfg.resume_slow ? tick_low : tick_high; // RQ11
  assign target = wup_target(cfg.warmup_count_select); // RQ11

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (clear) begin
      cnt_q <= '0; // RQ16
    end else if (run && tick && !done) begin
      cnt_q <= cnt_q + `HMPC_WUP_CNT_W'(1); // RQ16
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done <= 1'b0;
    end else if (clear) begin
      done <= 1'b0;
    end else if (run && tick && (cnt_q + `HMPC_WUP_CNT_W'(1) == target)) begin
      done <= 1'b1; // RQ9
    end
  end
endmodule : hmpc_warmup
`default_nettype wire

/* hmpc_checker.sv */
// assertions for the halt mode power controller
`timescale 1ns/1ps
`include "hmpc_map.svh"
`default_nettype none
module hmpc_checker #(
  parameter int NPERIPH = 8
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic HALT_REQ,
  input wire logic [`HMPC_MODE_W-1:0] HALT_MODE,
  input wire logic [NPERIPH-1:0] PERIPH_IDLE_ENABLE,
  input wire logic DRIVE_ENABLE,
  input wire logic CPU_RUN_EN,
  input wire logic SYS_CLK_EN,
  input wire logic [NPERIPH-1:0] PERIPH_CLK_EN,
  input wire logic CLOCK_TIMER_EN,
  input wire logic HIGH_OSC_EN,
  input wire logic LOW_OSC_EN,
  input wire logic PIN_DRIVE_EN,
  input wire hmpc_pkg::hmpc_buf_t BUF_EN,
  input wire hmpc_pkg::hmpc_state_t HALT_STATE,
  input wire logic WAKE_PULSE
);
  logic is_run, is_pi, is_oi, is_st;
  assign is_run = HALT_STATE == hmpc_pkg::ST_RUN;
  assign is_pi = HALT_STATE == hmpc_pkg::ST_PERIPH_IDLE;
  assign is_oi = HALT_STATE == hmpc_pkg::ST_OSC_IDLE;
  assign is_st = HALT_STATE == hmpc_pkg::ST_STOP;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  //////////////////////////////////////////////////////////////////////////
  a_cpu_held: assert property (!is_run |-> !CPU_RUN_EN)
    else $error("cpu enabled while halted");
  a_periph_sel: assert property (is_pi |-> SYS_CLK_EN && PERIPH_CLK_EN == PERIPH_IDLE_ENABLE)
    else $error("peripheral clocks differ from selection");
  a_osc_idle: assert property (is_oi |-> !SYS_CLK_EN && CLOCK_TIMER_EN && !(|PERIPH_CLK_EN))
    else $error("oscillator idle clocks wrong");
  a_stop_dead: assert property (is_st |-> !(HIGH_OSC_EN | LOW_OSC_EN | CLOCK_TIMER_EN | SYS_CLK_EN))
    else $error("something runs in stop");
  a_warmup_gate: assert property (HALT_STATE == hmpc_pkg::ST_WARMUP |-> !SYS_CLK_EN && !CPU_RUN_EN)
    else $error("system clock running during warm-up");
  a_mode_entry: assert property (HALT_REQ && is_run && HALT_MODE == `HMPC_MODE_OSC_IDLE |=> is_oi && !CPU_RUN_EN)
    else $error("oscillator idle not entered");
  a_drive_cap: assert property (HALT_REQ && is_run && HALT_MODE == `HMPC_MODE_STOP
    |=> is_st && PIN_DRIVE_EN == $past(DRIVE_ENABLE))
    else $error("stop pin drive wrong");
  a_bus_bufs: assert property (!is_run |-> !BUF_EN.muxed_bus_low_byte && !BUF_EN.wait_req)
    else $error("bus buffers on in halt");
  a_stop_bufs: assert property (is_st && !PIN_DRIVE_EN |-> BUF_EN == 5'h00)
    else $error("buffers on in undriven stop");
  a_wake_bufs: assert property (is_pi |-> BUF_EN.wake && BUF_EN.bus_request_input)
    else $error("wake buffers off in peripheral idle");
  a_wake_pulse: assert property ($rose(CPU_RUN_EN) |-> WAKE_PULSE ##1 !WAKE_PULSE)
    else $error("resume pulse wrong");
endmodule : hmpc_checker
bind hmpc_halt_ctrl hmpc_checker #(
  .NPERIPH(NPERIPH)
) u_chk (
  .CLK(CLK), .NRST(NRST), .HALT_REQ(HALT_REQ), .HALT_MODE(HALT_MODE),
  .PERIPH_IDLE_ENABLE(PERIPH_IDLE_ENABLE), .DRIVE_ENABLE(DRIVE_ENABLE), .CPU_RUN_EN(CPU_RUN_EN),
  .SYS_CLK_EN(SYS_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN), .CLOCK_TIMER_EN(CLOCK_TIMER_EN),
  .HIGH_OSC_EN(HIGH_OSC_EN), .LOW_OSC_EN(LOW_OSC_EN), .PIN_DRIVE_EN(PIN_DRIVE_EN),
  .BUF_EN(BUF_EN), .HALT_STATE(HALT_STATE), .WAKE_PULSE(WAKE_PULSE)
);
`default_nettype wire

/* testbench.sv */
// self-checking bench for the halt mode power controller
`timescale 1ns/1ps
`include "hmpc_map.svh"
`default_nettype none
module testbench;
  typedef struct packed {
    logic [1:0] m;
    logic [5:0] pin;
    hmpc_pkg::hmpc_state_t ent;
    hmpc_pkg::hmpc_state_t fin;
  } hmpc_row_t;
  logic clk, nrst, halt_req, drv, rslow, rhi, rlo, tkh, tkl;
  logic [1:0] halt_mode, wsel;
  logic [7:0] pie, pclk_en;
  logic [5:0] wake_pin, al_pi, al_oi, al_st, wsrc;
  logic cpu_en, sclk_en, ctim_en, hosc, losc, slow, pdrv, wpulse;
  hmpc_pkg::hmpc_buf_t buf_en;
  hmpc_pkg::hmpc_state_t st;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc_cnt = 0;
  hmpc_row_t rows[6] = '{
    '{`HMPC_MODE_PERIPH_IDLE, 6'h02, hmpc_pkg::ST_PERIPH_IDLE, hmpc_pkg::ST_RUN},
    '{`HMPC_MODE_PERIPH_IDLE, 6'h04, hmpc_pkg::ST_PERIPH_IDLE, hmpc_pkg::ST_PERIPH_IDLE},
    '{`HMPC_MODE_OSC_IDLE, 6'h04, hmpc_pkg::ST_OSC_IDLE, hmpc_pkg::ST_RUN},
    '{`HMPC_MODE_OSC_IDLE, 6'h02, hmpc_pkg::ST_OSC_IDLE, hmpc_pkg::ST_OSC_IDLE},
    '{`HMPC_MODE_OSC_IDLE, 6'h01, hmpc_pkg::ST_OSC_IDLE, hmpc_pkg::ST_RUN},
    '{`HMPC_MODE_NONE, 6'h02, hmpc_pkg::ST_RUN, hmpc_pkg::ST_RUN}};
  logic [1:0] sv[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  logic sl[4] = '{1'h0, 1'h1, 1'h0, 1'h1};
  int nt[4] = '{4, 8, 16, 4};
  logic [5:0] wk[4] = '{6'h08, 6'h08, 6'h01, 6'h08};
  hmpc_halt_ctrl #(.WUP_CNT_SHORT(4), .WUP_CNT_MID(8), .WUP_CNT_LONG(16)) DUT (
    .CLK(clk), .NRST(nrst), .HALT_REQ(halt_req), .HALT_MODE(halt_mode),
    .PERIPH_IDLE_ENABLE(pie), .DRIVE_ENABLE(drv), .RESUME_SLOW(rslow),
    .RESUME_HIGH_OSC_ENABLE(rhi), .RESUME_LOW_OSC_ENABLE(rlo), .WARMUP_COUNT_SELECT(wsel),
    .HIGH_FREQ_CLOCK_TICK(tkh), .LOW_FREQ_CLOCK_TICK(tkl), .WAKE_PIN(wake_pin),
    .WAKE_ALLOW_PERIPH_IDLE(al_pi), .WAKE_ALLOW_OSC_IDLE(al_oi), .WAKE_ALLOW_STOP(al_st),
    .CPU_RUN_EN(cpu_en), .SYS_CLK_EN(sclk_en), .PERIPH_CLK_EN(pclk_en), .CLOCK_TIMER_EN(ctim_en),
    .HIGH_OSC_EN(hosc), .LOW_OSC_EN(losc), .SLOW_MODE(slow), .PIN_DRIVE_EN(pdrv),
    .BUF_EN(buf_en), .HALT_STATE(st), .WAKE_SOURCE(wsrc), .WAKE_PULSE(wpulse));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  task automatic halt(input logic [1:0] m);
    @(posedge clk);
    halt_mode <= m;
    halt_req <= 1'h1;
    @(posedge clk);
    halt_req <= 1'h0;
    @(negedge clk);
  endtask : halt
  task automatic pins(input logic [5:0] p, input int n);
    @(posedge clk);
    wake_pin <= p;
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : pins
  task automatic tick(input logic lo);
    @(posedge clk);
    tkl <= lo;
    tkh <= !lo;
    @(posedge clk);
    tkl <= 1'h0;
    tkh <= 1'h0;
  endtask : tick
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    {nrst, halt_req, drv, rslow, rlo, tkh, tkl, halt_mode, wsel, wake_pin} <= '0;
    rhi <= 1'h1;
    pie <= 8'h5a;
    al_pi <= 6'h02;
    al_oi <= 6'h04;
    al_st <= 6'h08;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("reset state", hmpc_pkg::ST_RUN, st);
    chk("reset clocks", 8'hff, pclk_en);
    chk("reset high osc", 1'h1, hosc);
    chk("reset slow", 1'h0, slow);
    @(posedge clk);
    nrst <= 1'h1;
    foreach (rows[i]) begin
      halt(rows[i].m);
      chk("entry state", rows[i].ent, st);
      pins(rows[i].pin, 8);
      chk("release state", rows[i].fin, st);
      if (rows[i].m != `HMPC_MODE_NONE && rows[i].fin == hmpc_pkg::ST_RUN) begin
        chk("wake source", rows[i].pin, wsrc);
      end
      pins(6'h01, 8);
      pins(6'h00, 4);
      chk("run after nmi", hmpc_pkg::ST_RUN, st);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      wsel <= sv[i];
      rslow <= sl[i];
      rlo <= sl[i];
      drv <= i[0];
      halt(`HMPC_MODE_STOP);
      chk("stop drive", i[0], pdrv);
      tick(sl[i]);
      tick(sl[i]);
      pins(wk[i], 1);
      for (int k = 0; k < 20 && st !== hmpc_pkg::ST_WARMUP; k++) @(negedge clk);
      chk("warmup state", hmpc_pkg::ST_WARMUP, st);
      pins(6'h00, 1);
      repeat (nt[i] - 1) tick(sl[i]);
      repeat (3) tick(!sl[i]);
      @(negedge clk);
      chk("early state", hmpc_pkg::ST_WARMUP, st);
      chk("early clock", 1'h0, sclk_en);
      tick(sl[i]);
      @(posedge clk);
      @(negedge clk);
      chk("resume state", hmpc_pkg::ST_RUN, st);
      chk("resume speed", sl[i], slow);
      chk("resume low osc", sl[i], losc);
      chk("resume high osc", 1'h1, hosc);
    end
    halt(`HMPC_MODE_OSC_IDLE);
    @(posedge clk);
    nrst <= 1'h0;
    @(negedge clk);
    chk("reset in halt", hmpc_pkg::ST_RUN, st);
    chk("cpu after reset", 1'h1, cpu_en);
    chk("buffers in reset", 5'h00, buf_en);
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    halt(`HMPC_MODE_PERIPH_IDLE);
    chk("idle after reset", hmpc_pkg::ST_PERIPH_IDLE, st);
    chk("idle clocks", 8'h5a, pclk_en);
    chk("idle buffers", 5'h07, buf_en);
    chk("idle cpu", 1'h0, cpu_en);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
